// ===== design/spcw_ctrl.sv
// Purpose: Serial control word port, word register and mode decode of the speakerphone.
// Assumes: The host stops the serial clock while the latch strobe is high, so the shift
//          register is still when the core samples it.
// Notes:   Serial shifting runs on the link clock; everything else runs on core_clk.
//
// Contract
// - Mode codes 00 auto, 01 receive, 10 idle.
// - Mode code 11 forces transmit.
// - Range bit 0 wide, 1 reduced range.
// - Mute bit 1 mutes the microphone amplifier.
// - Volume binary, zero loudest, all ones quietest.
// - Volume codes give fifteen equal attenuation steps.
// - Reset pin low clears word after 30 us.
// - Word stays zero after reset until reloaded.
// - Forced modes override the speech detectors.
// - Auto with no speech falls to idle.
// - Auto with receive dominant selects receive.
// - Bits shifted MSB first on rising clock.
// - Strobe rising edge transfers shifted word.
// - Word cleared at power-up and chip disable.
`timescale 1ns/1ps
module spcw_ctrl (
  // Core clock and reset.
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  // Serial link pins.
  input  wire logic                ser_clk,
  input  wire logic                ser_data,
  input  wire logic                latch_strobe_input,
  // Control pins.
  input  wire logic                reg_reset_n,
  input  wire logic                chip_disable_input,
  // Speech detector levels.
  input  wire spcw_pkg::spcw_det_t det,
  // Decoded outputs to the analog side.
  output      spcw_pkg::spcw_word_t ctrl_word,
  output      spcw_pkg::spcw_mode_t mode,
  output      logic                rx_drive,
  output      logic                tx_drive,
  output      logic                range_reduced,
  output      logic                mic_muted,
  output      logic [3:0]          vol_step
);
  import spcw_pkg::*;

  // ==========================================================================
  // Link domain: shift register
  // ==========================================================================
  logic [WORD_BITS-1:0] shift_word;

  // Each rising edge shifts one bit in; the first bit ends up as bit 7.
  always_ff @(posedge ser_clk) begin
    shift_word <= {shift_word[WORD_BITS-2:0], ser_data};
  end

  // The shift register has no reset, so the word is compared only once eight bits have gone in.
  a_shift_order: assert property (@(posedge ser_clk) disable iff (chip_disable_input)
    ##8 shift_word == {$past(ser_data, 8), $past(ser_data, 7), $past(ser_data, 6), $past(ser_data, 5),
                       $past(ser_data, 4), $past(ser_data, 3), $past(ser_data, 2), $past(ser_data, 1)})
    else $error("serial bit not shifted in order");

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  logic [SYNC_BITS-1:0] sync_a;
  logic [SYNC_BITS-1:0] sync_b;
  logic                 strobe_d;
  logic                 strobe_s;
  logic                 por_low;
  logic                 cd_act;
  spcw_det_t            det_s;

  // Two flops on the strobe, reset, disable and detector pins before any logic looks at them.
  // The strobe idles high, so its flops reset high; a low reset value would fake a rising edge.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync_a <= {1'b1, {(SYNC_BITS-1){1'b0}}};
      sync_b <= {1'b1, {(SYNC_BITS-1){1'b0}}};
    end else begin
      sync_a <= {latch_strobe_input, ~reg_reset_n, chip_disable_input, det};
      sync_b <= sync_a;
    end
  end

  assign strobe_s = sync_b[5];
  assign por_low  = sync_b[4];
  assign cd_act   = sync_b[3];
  assign det_s    = sync_b[2:0];

  // Delayed copy of the synchronised strobe for edge detection.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      strobe_d <= 1'b1;
    end else begin
      strobe_d <= strobe_s;
    end
  end

  // ==========================================================================
  // Register reset delay
  // ==========================================================================
  logic [CLR_CNT_W-1:0] clr_cnt;
  logic                 clr_fire;

  // Once the reset pin is seen low the clear completes, even if it is released early.
  assign clr_fire = (clr_cnt == CLR_CNT_W'(CLR_CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (sys_rst || cd_act) begin
      clr_cnt <= '0;
    end else if (clr_fire) begin
      clr_cnt <= '0;
    end else if (por_low || clr_cnt != '0) begin
      clr_cnt <= clr_cnt + CLR_CNT_W'(1);
    end
  end

  // ==========================================================================
  // Control word register
  // ==========================================================================
  logic latch_ev;
  logic clr_hold;

  // The word is sampled only after the strobe has crossed, when the link has gone quiet.
  assign latch_ev = strobe_s && !strobe_d;
  // While the reset pin stays low after the delay, the word is held at zero.
  assign clr_hold = clr_fire || (por_low && clr_cnt == '0 && ctrl_word == WORD_RESET);

  // A single register carries every field, so no output shows half a word.
  always_ff @(posedge core_clk) begin
    if (sys_rst || cd_act) begin
      ctrl_word <= WORD_RESET;
    end else if (clr_hold) begin
      ctrl_word <= WORD_RESET;
    end else if (latch_ev && !por_low) begin
      ctrl_word <= spcw_word_t'(shift_word);
    end
  end

  // ==========================================================================
  // Mode decision
  // ==========================================================================
  spcw_mode_t next_mode;

  // Forced codes win over the detectors; auto follows the detectors.
  always_comb begin
    unique case (ctrl_word.mode_select_field)
      MODE_FRX:   next_mode = SPCW_RX;
      MODE_FIDLE: next_mode = SPCW_IDLE;
      MODE_FTX:   next_mode = SPCW_TX;
      MODE_AUTO: begin
        if (!det_s.tx_speech && !det_s.rx_speech) begin
          next_mode = SPCW_IDLE;
        end else if (det_s.rx_speech && det_s.rx_dominant) begin
          next_mode = SPCW_RX;
        end else if (det_s.tx_speech) begin
          next_mode = SPCW_TX;
        end else begin
          next_mode = SPCW_RX;
        end
      end
    endcase
  end

  // Registered outputs; drive sources are off in idle.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode          <= SPCW_IDLE;
      rx_drive      <= 1'b0;
      tx_drive      <= 1'b0;
      range_reduced <= 1'b0;
      mic_muted     <= 1'b0;
      vol_step      <= VOL_MAX;
    end else begin
      mode          <= next_mode;
      rx_drive      <= (next_mode == SPCW_RX);
      tx_drive      <= (next_mode == SPCW_TX);
      range_reduced <= ctrl_word.range_select_bit;
      mic_muted     <= ctrl_word.mic_mute_bit;
      // Volume acts only in receive; each code is one equal step of attenuation.
      vol_step      <= (next_mode == SPCW_RX) ? ctrl_word.volume_field : VOL_MAX;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  logic                 por_low_d;
  logic [CLR_CNT_W-1:0] por_age;

  // Check helper: cycles since the reset pin was seen to fall. A counter stands in for a long delay range.
  always_ff @(posedge core_clk) begin
    if (sys_rst || cd_act) begin
      por_low_d <= 1'b0;
      por_age   <= '0;
    end else begin
      por_low_d <= por_low;
      if (por_age == CLR_CNT_W'(CLR_CYCLES)) begin
        por_age <= '0;
      end else if ((por_low && !por_low_d && por_age == '0) || por_age != '0) begin
        por_age <= por_age + CLR_CNT_W'(1);
      end
    end
  end

  sequence s_por_held;
    !por_low ##1 por_low;
  endsequence

  a_por_start: assert property (@(posedge core_clk) disable iff (sys_rst || cd_act)
    s_por_held |=> clr_cnt != '0 || ctrl_word == WORD_RESET)
    else $error("register reset did not start the clear delay");

  a_forced_rx: assert property (@(posedge core_clk) disable iff (sys_rst)
    ctrl_word.mode_select_field == MODE_FRX |=> mode == SPCW_RX && rx_drive && !tx_drive)
    else $error("forced receive not applied");

  a_forced_tx: assert property (@(posedge core_clk) disable iff (sys_rst)
    ctrl_word.mode_select_field == MODE_FTX |=> mode == SPCW_TX && tx_drive && !rx_drive)
    else $error("forced transmit not applied");

  a_forced_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
    ctrl_word.mode_select_field == MODE_FIDLE |=> mode == SPCW_IDLE && !tx_drive && !rx_drive)
    else $error("forced idle not applied");

  a_range_mute: assert property (@(posedge core_clk) disable iff (sys_rst)
    ##1 range_reduced == $past(ctrl_word.range_select_bit) && mic_muted == $past(ctrl_word.mic_mute_bit))
    else $error("range or mute output wrong");

  a_auto_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
    ctrl_word.mode_select_field == MODE_AUTO && !det_s.tx_speech && !det_s.rx_speech
      |=> mode == SPCW_IDLE && !rx_drive && !tx_drive)
    else $error("auto mode did not fall to idle");

  a_auto_rx: assert property (@(posedge core_clk) disable iff (sys_rst)
    ctrl_word.mode_select_field == MODE_AUTO && det_s.rx_speech && det_s.rx_dominant
      |=> mode == SPCW_RX && vol_step == $past(ctrl_word.volume_field))
    else $error("auto mode did not select receive");

  a_latch_word: assert property (@(posedge core_clk) disable iff (sys_rst)
    latch_ev && !por_low && !cd_act && !clr_hold |=> ctrl_word == $past(shift_word))
    else $error("strobe did not transfer word");

  a_disable_clr: assert property (@(posedge core_clk) disable iff (sys_rst)
    cd_act |=> ctrl_word == WORD_RESET)
    else $error("chip disable did not clear word");

  a_por_delay: assert property (@(posedge core_clk) disable iff (sys_rst || cd_act)
    por_age == CLR_CNT_W'(CLR_CYCLES) |-> ctrl_word == WORD_RESET)
    else $error("register reset did not clear word in time");

  a_por_stays: assert property (@(posedge core_clk) disable iff (sys_rst)
    ctrl_word == WORD_RESET && !latch_ev |=> ctrl_word == WORD_RESET)
    else $error("word changed without a new load");

endmodule

// ===== inc/spcw_pkg.sv
// Purpose: Shared constants and types for the speakerphone control word block.
// Assumes: Core clock of 40 MHz; serial link clocked by the host.
// Notes:   Field positions follow the eight-bit word, first bit shifted in is bit 7.
package spcw_pkg;

  // ==========================================================================
  // Word layout and reset value
  // ==========================================================================
  localparam int          WORD_BITS  = 8;
  localparam int          MODE_MSB   = 7;
  localparam int          MODE_LSB   = 6;
  localparam int          RANGE_POS  = 5;
  localparam int          MUTE_POS   = 4;
  localparam int          VOL_MSB    = 3;
  localparam int          VOL_LSB    = 0;
  localparam logic [7:0]  WORD_RESET = 8'h00;

  // Mode field codes.
  localparam logic [1:0]  MODE_AUTO  = 2'h0;
  localparam logic [1:0]  MODE_FRX   = 2'h1;
  localparam logic [1:0]  MODE_FIDLE = 2'h2;
  localparam logic [1:0]  MODE_FTX   = 2'h3;

  // Volume codes: zero is loudest, all ones is quietest, fifteen steps between.
  localparam logic [3:0]  VOL_MAX    = 4'h0;
  localparam logic [3:0]  VOL_MIN    = 4'hF;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int          CLK_PERIOD_PS = 25000;
  localparam int          CLR_DELAY_US  = 30;
  // Least time, so round up to whole cycles.
  localparam int          CLR_CYCLES    = (CLR_DELAY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          CLR_CNT_W     = $clog2(CLR_CYCLES + 1);
  localparam int          SYNC_BITS     = 6;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic [1:0] mode_select_field;
    logic       range_select_bit;
    logic       mic_mute_bit;
    logic [3:0] volume_field;
  } spcw_word_t;

  typedef enum logic [1:0] {
    SPCW_IDLE,
    SPCW_RX,
    SPCW_TX
  } spcw_mode_t;

  // Detector levels coming from the analog side.
  typedef struct packed {
    logic tx_speech;
    logic rx_speech;
    logic rx_dominant;
  } spcw_det_t;

endpackage

// ===== bench/spcw_host.sv
// Purpose: Host model that loads control words over the three-wire serial port.
// Assumes: Link clock of 80 ns period, idle low outside frames.
// Notes:   Data line shows the inverse of the last bit once a frame is over.
`timescale 1ns/1ps
module spcw_host (
  // Serial link pins.
  output logic ser_clk,
  output logic ser_data,
  output logic latch_strobe_input
);
  // ==========================================================================
  // Idle state and frame task
  // ==========================================================================
  initial begin
    ser_clk            = 1'b0;
    ser_data           = 1'b0;
    latch_strobe_input = 1'b1;
  end

  // Strobe drops before any clock edge, so the device never latches a half word.
  task automatic send(input logic [7:0] w);
    #7;
    latch_strobe_input = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      ser_data = w[i];
      #40 ser_clk = 1'b1;
      #40 ser_clk = 1'b0;
    end
    ser_data = ~w[0];
    #40 latch_strobe_input = 1'b1;
    #200;
  endtask
endmodule

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the speakerphone control word block.
// Assumes: Outputs settle within eight core cycles of a strobe or pin change.
// Notes:   Notes of expected outputs are queued and checked by a monitor.
`timescale 1ns/1ps
module tb_top;
  import spcw_pkg::*;
  typedef struct packed {
    spcw_word_t w;
    spcw_mode_t m;
    logic       rx;
    logic       tx;
    logic       rng;
    logic       mute;
    logic [3:0] vol;
  } spcw_exp_t;

  logic       core_clk, sys_rst, reg_reset_n, chip_disable_input;
  logic       ser_clk, ser_data, latch_strobe_input;
  spcw_det_t  det;
  spcw_word_t ctrl_word;
  spcw_mode_t mode;
  logic       rx_drive, tx_drive, range_reduced, mic_muted;
  logic [3:0] vol_step;
  logic [7:0] rnd, w;
  int         err_total, num_checks;
  spcw_exp_t  notes[$];
  event       ev_look;

  spcw_ctrl spcw_ctrl_i (.core_clk(core_clk), .sys_rst(sys_rst), .ser_clk(ser_clk), .ser_data(ser_data),
    .latch_strobe_input(latch_strobe_input), .reg_reset_n(reg_reset_n),
    .chip_disable_input(chip_disable_input), .det(det), .ctrl_word(ctrl_word), .mode(mode),
    .rx_drive(rx_drive), .tx_drive(tx_drive), .range_reduced(range_reduced), .mic_muted(mic_muted),
    .vol_step(vol_step));
  spcw_host spcw_host_i (.ser_clk(ser_clk), .ser_data(ser_data), .latch_strobe_input(latch_strobe_input));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  always #12.5 core_clk = ~core_clk;

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  // Model of the decode; auto mode weighs the detector levels.
  function automatic spcw_exp_t f_exp(input spcw_word_t cw, input spcw_det_t d);
    spcw_mode_t m;
    case (cw.mode_select_field)
      MODE_FRX:   m = SPCW_RX;
      MODE_FIDLE: m = SPCW_IDLE;
      MODE_FTX:   m = SPCW_TX;
      default:    m = !(d.tx_speech | d.rx_speech) ? SPCW_IDLE :
                      (d.rx_speech & d.rx_dominant) ? SPCW_RX : d.tx_speech ? SPCW_TX : SPCW_RX;
    endcase
    return {cw, m, m == SPCW_RX, m == SPCW_TX, cw.range_select_bit, cw.mic_mute_bit,
            (m == SPCW_RX) ? cw.volume_field : 4'h0};
  endfunction

  task automatic chk(input spcw_exp_t exp_v, input spcw_exp_t got_v);
    num_checks++;
    if (got_v !== exp_v) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask

  // Settling wait is fixed by the latch and synchroniser latency.
  task automatic look(input logic [7:0] cw);
    repeat (8) @(negedge core_clk);
    notes.push_back(f_exp(cw, det));
    ->ev_look;
  endtask

  // Monitor takes the oldest note when outputs are due.
  always @(ev_look) begin
    chk(notes.pop_front(), {ctrl_word, mode, rx_drive, tx_drive, range_reduced, mic_muted, vol_step});
  end

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #300us;
    err_total++;
    wrap_up();
  end

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    core_clk = 0; sys_rst = 1; reg_reset_n = 1; chip_disable_input = 0; det = '0; rnd = 8'h15;
    repeat (6) @(negedge core_clk);
    sys_rst = 0;
    look(WORD_RESET);
    // Every mode code against every detector pattern, back to back.
    for (int i = 0; i < 32; i++) begin
      rnd = lfsr(rnd);
      w = {i[1:0], rnd[5:0]};
      det = i[4:2];
      spcw_host_i.send(w);
      look(w);
    end
    $display("test modes done");
    // Short reset pulse: clear lands after the full delay, then holds.
    w = 8'h10;
    spcw_host_i.send(w);
    @(negedge core_clk);
    reg_reset_n = 0;
    repeat (10) @(negedge core_clk);
    reg_reset_n = 1;
    repeat (1130) @(negedge core_clk);
    look(w);
    repeat (60) @(negedge core_clk);
    look(8'h00);
    $display("test reg reset done");
    // Chip disable clears and refuses new words.
    spcw_host_i.send(8'hC5);
    look(8'hC5);
    chip_disable_input = 1;
    look(8'h00);
    spcw_host_i.send(8'h7A);
    look(8'h00);
    chip_disable_input = 0;
    look(8'h00);
    spcw_host_i.send(8'h6B);
    look(8'h6B);
    $display("test disable done");
    wrap_up();
  end
endmodule
